/* rtl/crx_defs.vh */
`ifndef CRX_DEFS_VH
`define CRX_DEFS_VH

// register byte offsets on the bus
`define CRX_OFS_RX_DONE     8'h00
`define CRX_OFS_REMOTE_REQ  8'h04
`define CRX_OFS_EVENT_STAT  8'h08
`define CRX_OFS_MBOX_MASK   8'h0C
`define CRX_OFS_IRQ_STATUS  8'h10
`define CRX_OFS_IRQ_CLEAR   8'h14
`define CRX_OFS_IRQ_ENABLE  8'h18
`define CRX_OFS_ERR_COUNT   8'h1C

// can_event_status field positions
`define CRX_EV_OVERLOAD     15
`define CRX_EV_BUS_OFF      14
`define CRX_EV_ERR_PASSIVE  13
`define CRX_EV_RX_WARNING   12
`define CRX_EV_REMOTE_IRQ   10
`define CRX_EV_RX_MSG_IRQ   9

// sticky interrupt status / clear / enable layout
`define CRX_IRQ_RX_MSG      0
`define CRX_IRQ_REMOTE      1
`define CRX_IRQ_OVERLOAD    2
`define CRX_IRQ_BUS_OFF     3
`define CRX_IRQ_ERR_PASSIVE 4
`define CRX_IRQ_RX_WARNING  5
`define CRX_IRQ_WIDTH       6

// reset values
`define CRX_RST_FLAGS       16'h0000
`define CRX_RST_MBOX_MASK   16'hFFFF
`define CRX_RST_IRQ_ENABLE  6'h00

// error counter thresholds (9-bit counters)
`define CRX_LIM_BUS_OFF     9'h100
`define CRX_LIM_ERR_PASSIVE 9'h080
`define CRX_LIM_RX_WARNING  9'h060

// bus encodings
`define CRX_HTRANS_NONSEQ   2'h2
`define CRX_HSIZE_WORD      3'h2

`endif

/* rtl/crx_w1c_flags.v */
`timescale 1ns/1ns
// sticky flags: hardware set beats a same-cycle write-one clear
module crx_w1c_flags
#(
    parameter WIDTH = 16
)
(
    input  wire             ref_clk_in,
    input  wire             srst_in,
    input  wire [WIDTH-1:0] set_in,
    input  wire [WIDTH-1:0] clr_in,
    output wire [WIDTH-1:0] flags_next_out,
    output wire [WIDTH-1:0] flags_out
);
    reg  [WIDTH-1:0] flags_reg;

    // set has priority so no event is lost
    assign flags_next_out = set_in | (flags_reg & ~clr_in);
    assign flags_out      = flags_reg;

    // flags come up clear
    always @(posedge ref_clk_in)
    begin
        if (srst_in)
            flags_reg <= {WIDTH{1'b0}};
        else
            flags_reg <= flags_next_out;
    end
endmodule // crx_w1c_flags

/* rtl/crx_rise_det.v */
`timescale 1ns/1ns
// turns threshold levels into one-cycle entry pulses
module crx_rise_det
#(
    parameter WIDTH = 3
)
(
    input  wire             ref_clk_in,
    input  wire             srst_in,
    input  wire [WIDTH-1:0] level_in,
    output wire [WIDTH-1:0] rise_out
);
    reg  [WIDTH-1:0] level_reg;

    // a level already high at reset release counts as an entry
    assign rise_out = level_in & ~level_reg;

    // previous level per lane
    always @(posedge ref_clk_in)
    begin
        if (srst_in)
            level_reg <= {WIDTH{1'b0}};
        else
            level_reg <= level_in;
    end
endmodule // crx_rise_det

/* rtl/crx_flags.v */
// Our own choices: the AHB-Lite register port and the register offsets.
`timescale 1ns/1ns
`include "crx_defs.vh"

// Functional notes
// - error-free data or remote reception sets that mailbox's receive-done bit
// - bits 15..8 hold mailboxes 7..0, bits 7..0 hold 15..8
// - error-free remote frame reception sets that mailbox's remote-request bit
// - remote frame sets remote-request and receive-done bits together
// - writing 1 clears a mailbox flag; zeros ignored; software cannot set
// - overload frame sent while not bus-off sets event bit 15
// - transmit errors reaching 256 set event bit 14
// - transmit or receive errors reaching 128 set event bit 13
// - receive errors reaching 96 set event bit 12
// - all mailbox flags and event bits 15..12 are zero after reset
// - receive-message flag rises on unmasked reception, falls when all cleared
// - remote-request flag rises on unmasked remote frame, falls when all cleared
module crx_flags
(
    input  wire        ref_clk_in,
    input  wire        srst_in,
    // ahb-lite slave
    input  wire        hsel_in,
    input  wire [7:0]  haddr_in,
    input  wire [1:0]  htrans_in,
    input  wire        hwrite_in,
    input  wire [2:0]  hsize_in,
    input  wire [31:0] hwdata_in,
    input  wire        hready_in,
    output wire [31:0] hrdata_out,
    output wire        hreadyout_out,
    output wire        hresp_out,
    // frame engine side
    input  wire        rx_done_valid_in,
    input  wire [3:0]  rx_mailbox_in,
    input  wire        rx_is_remote_in,
    input  wire        overload_tx_in,
    input  wire [8:0]  tx_err_count_in,
    input  wire [8:0]  rx_err_count_in,
    // interrupt
    output wire        irq_out
);
    // ahb data phase state
    reg         wr_pend_reg;
    reg  [7:0]  wr_addr_reg;
    reg  [31:0] hrdata_reg;
    reg         hreadyout_reg;
    reg         hresp_reg;
    reg         irq_reg;

    // software held registers
    reg  [15:0] mbox_mask_reg;
    reg  [5:0]  irq_enable_reg;

    // flag vectors
    wire [15:0] rx_done_q;
    wire [15:0] rx_done_next;
    wire [15:0] remote_q;
    wire [15:0] remote_next;
    wire [3:0]  event_q;
    wire [1:0]  msg_irq_q;
    wire [5:0]  irq_stat_q;
    wire [5:0]  irq_stat_next;

    // decode and set/clear vectors
    wire        addr_phase;
    wire        wr_now;
    wire        wr_rx_done;
    wire        wr_remote;
    wire        wr_event;
    wire        wr_mask;
    wire        wr_irq_clear;
    wire        wr_irq_enable;
    wire [15:0] mbox_onehot;
    wire [15:0] rx_set_bits;
    wire [15:0] remote_set_bits;
    wire [2:0]  err_level;
    wire [2:0]  err_rise;
    wire        bus_off_now;
    wire        overload_ev;
    wire [3:0]  event_set;
    wire [3:0]  event_clr;
    wire        unmasked_hit;
    wire [1:0]  msg_irq_set;
    wire [1:0]  msg_irq_clr;
    wire [5:0]  irq_events;
    wire [31:0] rd_data;
    reg  [31:0] rd_mux;

    // a transfer is taken when selected, nonseq and the bus is ready
    // size is not decoded: every register is one whole word, so a
    // narrow write would clear the same bits as a word write
    assign addr_phase = hsel_in & hready_in
                      & (htrans_in == `CRX_HTRANS_NONSEQ);

    // writes take effect at the end of their data phase
    assign wr_now        = wr_pend_reg & hready_in;
    assign wr_rx_done    = wr_now & (wr_addr_reg == `CRX_OFS_RX_DONE);
    assign wr_remote     = wr_now & (wr_addr_reg == `CRX_OFS_REMOTE_REQ);
    assign wr_event      = wr_now & (wr_addr_reg == `CRX_OFS_EVENT_STAT);
    assign wr_mask       = wr_now & (wr_addr_reg == `CRX_OFS_MBOX_MASK);
    assign wr_irq_clear  = wr_now & (wr_addr_reg == `CRX_OFS_IRQ_CLEAR);
    assign wr_irq_enable = wr_now & (wr_addr_reg == `CRX_OFS_IRQ_ENABLE);

    // ahb address capture and zero-wait answer
    always @(posedge ref_clk_in)
    begin
        if (srst_in)
        begin
            wr_pend_reg   <= 1'b0;
            wr_addr_reg   <= 8'h00;
            hrdata_reg    <= 32'h00000000;
            hreadyout_reg <= 1'b1;
            hresp_reg     <= 1'b0;
        end
        else
        begin
            hreadyout_reg <= 1'b1;
            // okay only: no register refuses an access
            hresp_reg     <= 1'b0;
            if (hready_in)
            begin
                wr_pend_reg <= addr_phase & hwrite_in;
                wr_addr_reg <= {haddr_in[7:2], 2'b00};
                // reads sample state at the address phase edge
                if (addr_phase & ~hwrite_in)
                    hrdata_reg <= rd_data;
                else
                    hrdata_reg <= 32'h00000000;
            end
        end
    end

    // the slave never stalls and never errors
    assign hreadyout_out = hreadyout_reg;
    assign hresp_out     = hresp_reg;
    assign hrdata_out    = hrdata_reg;

    // one-hot of the mailbox that just finished
    assign mbox_onehot = rx_done_valid_in
                       ? (16'h0001 << rx_mailbox_in) : 16'h0000;

    // byte swap mapping
    // low mailboxes land in the upper byte of every per-mailbox register
    assign rx_set_bits = {mbox_onehot[7:0], mbox_onehot[15:8]};

    // paired remote setting
    // remote bits reuse the same set vector, gated by frame type
    assign remote_set_bits = rx_is_remote_in ? rx_set_bits : 16'h0000;

    crx_w1c_flags
    #(
        .WIDTH          (16)
    )
    u_rx_done
    (
        .ref_clk_in     (ref_clk_in),
        .srst_in        (srst_in),
        .set_in         (rx_set_bits),
        .clr_in         (wr_rx_done ? hwdata_in[15:0] : 16'h0000),
        .flags_next_out (rx_done_next),
        .flags_out      (rx_done_q)
    );

    crx_w1c_flags
    #(
        .WIDTH          (16)
    )
    u_remote
    (
        .ref_clk_in     (ref_clk_in),
        .srst_in        (srst_in),
        .set_in         (remote_set_bits),
        .clr_in         (wr_remote ? hwdata_in[15:0] : 16'h0000),
        .flags_next_out (remote_next),
        .flags_out      (remote_q)
    );

    // threshold levels, order: bus-off, error passive, rx warning
    assign err_level[2] = tx_err_count_in >= `CRX_LIM_BUS_OFF;
    assign err_level[1] = (tx_err_count_in >= `CRX_LIM_ERR_PASSIVE)
                        | (rx_err_count_in >= `CRX_LIM_ERR_PASSIVE);
    assign err_level[0] = rx_err_count_in >= `CRX_LIM_RX_WARNING;

    // entry pulses, so a clear sticks while the counter stays high
    crx_rise_det
    #(
        .WIDTH      (3)
    )
    u_err_rise
    (
        .ref_clk_in (ref_clk_in),
        .srst_in    (srst_in),
        .level_in   (err_level),
        .rise_out   (err_rise)
    );

    // overload only counts while not bus-off
    assign bus_off_now = err_level[2];
    assign overload_ev = overload_tx_in & ~bus_off_now;

    // event bits 15..12 packed as [3]=overload .. [0]=rx warning
    // overload plus bus-off, error passive and rx warning entry
    assign event_set = {overload_ev, err_rise[2], err_rise[1], err_rise[0]};
    assign event_clr = wr_event
                     ? hwdata_in[`CRX_EV_OVERLOAD:`CRX_EV_RX_WARNING]
                     : 4'h0;

    crx_w1c_flags
    #(
        .WIDTH          (4)
    )
    u_event
    (
        .ref_clk_in     (ref_clk_in),
        .srst_in        (srst_in),
        .set_in         (event_set),
        .clr_in         (event_clr),
        .flags_next_out (),
        .flags_out      (event_q)
    );

    // mask uses the same swapped layout, so this lines up bit for bit
    assign unmasked_hit = |(rx_set_bits & ~mbox_mask_reg);

    // receive-message and remote-request flags
    // held while any flag of its register survives this cycle
    assign msg_irq_set = {unmasked_hit & rx_is_remote_in, unmasked_hit};
    assign msg_irq_clr = {~(|remote_next), ~(|rx_done_next)};

    crx_w1c_flags
    #(
        .WIDTH          (2)
    )
    u_msg_irq
    (
        .ref_clk_in     (ref_clk_in),
        .srst_in        (srst_in),
        .set_in         (msg_irq_set),
        .clr_in         (msg_irq_clr),
        .flags_next_out (),
        .flags_out      (msg_irq_q)
    );

    // sticky interrupt status fed by every event of the block
    assign irq_events = {err_rise[0], err_rise[1], err_rise[2],
                         overload_ev, msg_irq_set[1], msg_irq_set[0]};

    crx_w1c_flags
    #(
        .WIDTH          (`CRX_IRQ_WIDTH)
    )
    u_irq_stat
    (
        .ref_clk_in     (ref_clk_in),
        .srst_in        (srst_in),
        .set_in         (irq_events),
        .clr_in         (wr_irq_clear ? hwdata_in[5:0] : 6'h00),
        .flags_next_out (irq_stat_next),
        .flags_out      (irq_stat_q)
    );

    // mask and enable registers
    always @(posedge ref_clk_in)
    begin
        if (srst_in)
        begin
            mbox_mask_reg  <= `CRX_RST_MBOX_MASK;
            irq_enable_reg <= `CRX_RST_IRQ_ENABLE;
        end
        else
        begin
            if (wr_mask)
                mbox_mask_reg <= hwdata_in[15:0];
            if (wr_irq_enable)
                irq_enable_reg <= hwdata_in[5:0];
        end
    end

    // level interrupt from next-state values so the output is a flop
    always @(posedge ref_clk_in)
    begin
        if (srst_in)
            irq_reg <= 1'b0;
        else
            irq_reg <= |(irq_stat_next
                         & (wr_irq_enable ? hwdata_in[5:0]
                                          : irq_enable_reg));
    end

    assign irq_out = irq_reg;

    // read mux; unmapped and write-only offsets read zero
    always @*
    begin
        rd_mux = 32'h00000000;
        case ({haddr_in[7:2], 2'b00})
            `CRX_OFS_RX_DONE:
                rd_mux[15:0] = rx_done_q;
            `CRX_OFS_REMOTE_REQ:
                rd_mux[15:0] = remote_q;
            `CRX_OFS_EVENT_STAT:
            begin
                rd_mux[`CRX_EV_OVERLOAD:`CRX_EV_RX_WARNING] = event_q;
                rd_mux[`CRX_EV_REMOTE_IRQ] = msg_irq_q[1];
                rd_mux[`CRX_EV_RX_MSG_IRQ] = msg_irq_q[0];
            end
            `CRX_OFS_MBOX_MASK:
                rd_mux[15:0] = mbox_mask_reg;
            `CRX_OFS_IRQ_STATUS:
                rd_mux[5:0] = irq_stat_q;
            `CRX_OFS_IRQ_ENABLE:
                rd_mux[5:0] = irq_enable_reg;
            `CRX_OFS_ERR_COUNT:
            begin
                rd_mux[24:16] = rx_err_count_in;
                rd_mux[8:0]   = tx_err_count_in;
            end
            default:
                rd_mux = 32'h00000000;
        endcase
    end

    assign rd_data = rd_mux;
endmodule // crx_flags

/* tb/crx_can_node.sv */
`timescale 1ns/1ns
// stands in for the bus nodes: finished frames and error counters
module crx_can_node
(
    input  wire       ref_clk_in,
    output reg        rx_done_valid_out,
    output reg  [3:0] rx_mailbox_out,
    output reg        rx_is_remote_out,
    output reg        overload_tx_out,
    output reg  [8:0] tx_err_count_out,
    output reg  [8:0] rx_err_count_out
);
    // quiet bus at time zero
    initial
    begin
        rx_done_valid_out = 1'b0;
        rx_mailbox_out    = 4'h0;
        rx_is_remote_out  = 1'b0;
        overload_tx_out   = 1'b0;
        tx_err_count_out  = 9'h000;
        rx_err_count_out  = 9'h000;
    end
    task frame(input [3:0] mb, input rem);
    begin
        rx_done_valid_out <= 1'b1;
        rx_mailbox_out    <= mb;
        rx_is_remote_out  <= rem;
        @(posedge ref_clk_in);
        rx_done_valid_out <= 1'b0;
        // no stale qualifiers once the pulse is gone
        rx_mailbox_out    <= ~mb;
        rx_is_remote_out  <= ~rem;
    end
    endtask
    task overload;
    begin
        overload_tx_out <= 1'b1;
        @(posedge ref_clk_in);
        overload_tx_out <= 1'b0;
    end
    endtask
    task counts(input [8:0] tec, input [8:0] rec);
    begin
        tx_err_count_out <= tec;
        rx_err_count_out <= rec;
        repeat (3) @(posedge ref_clk_in);
    end
    endtask
endmodule // crx_can_node

/* tb/crx_flags_monitor.sv */
`timescale 1ns/1ns
module crx_flags_monitor
(
    input wire        ref_clk_in,
    input wire        srst_in,
    input wire        hsel_in,
    input wire [7:0]  haddr_in,
    input wire [1:0]  htrans_in,
    input wire        hwrite_in,
    input wire        hready_in,
    input wire [31:0] hrdata_out,
    input wire        hreadyout_out,
    input wire        hresp_out,
    input wire        rx_done_valid_in,
    input wire        overload_tx_in,
    input wire [8:0]  tx_err_count_in,
    input wire [8:0]  rx_err_count_in,
    input wire        irq_out
);
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (srst_in);
    wire        tk = hsel_in && hready_in && htrans_in == 2'h2;
    reg         rd_reg;
    reg         wr_reg;
    reg  [5:0]  ad_reg;
    reg  [17:0] cnt_reg;
    // data phase tracking, one cycle behind the address phase
    always @(posedge ref_clk_in)
    begin
        rd_reg  <= tk && !hwrite_in;
        wr_reg  <= tk && hwrite_in;
        ad_reg  <= haddr_in[7:2];
        cnt_reg <= {rx_err_count_in, tx_err_count_in};
    end
    // anything that may legally lift the interrupt
    wire cause = rx_done_valid_in || overload_tx_in || wr_reg ||
                 cnt_reg != {rx_err_count_in, tx_err_count_in};

    a_ready_high: assert property (hreadyout_out)
        else $error("hreadyout low");
    a_resp_okay: assert property (!hresp_out)
        else $error("hresp not okay");
    a_rdata_idle: assert property (!rd_reg |-> hrdata_out == 32'h0)
        else $error("hrdata outside read");
    a_irq_reset: assert property ($past(srst_in) |-> !irq_out)
        else $error("irq after reset");
    a_count_read: assert property (rd_reg && ad_reg == 6'h7 |->
        hrdata_out == {7'h0, cnt_reg[17:9], 7'h0, cnt_reg[8:0]})
        else $error("counter read wrong");
    a_upper_zero: assert property (rd_reg && ad_reg < 6'h3 |->
        hrdata_out[31:16] == 16'h0) else $error("upper bits set");
    a_irq_fall: assert property ($fell(irq_out) |->
        $past(wr_reg) || $past(wr_reg, 2)) else $error("irq fell alone");
    a_irq_cause: assert property ($rose(irq_out) |->
        $past(cause) || $past(cause, 2) || $past(cause, 3))
        else $error("irq rose alone");
    c_frame: cover property (rx_done_valid_in);
    c_irq: cover property ($rose(irq_out));
    c_count: cover property (rd_reg && ad_reg == 6'h7);
endmodule // crx_flags_monitor

bind crx_flags crx_flags_monitor crx_flags_monitor_inst
(
    .ref_clk_in(ref_clk_in), .srst_in(srst_in), .hsel_in(hsel_in),
    .haddr_in(haddr_in), .htrans_in(htrans_in), .hwrite_in(hwrite_in),
    .hready_in(hready_in), .hrdata_out(hrdata_out),
    .hreadyout_out(hreadyout_out), .hresp_out(hresp_out),
    .rx_done_valid_in(rx_done_valid_in), .overload_tx_in(overload_tx_in),
    .tx_err_count_in(tx_err_count_in), .rx_err_count_in(rx_err_count_in),
    .irq_out(irq_out)
);

/* tb/crx_flags_bench.sv */
`timescale 1ns/1ns
module crx_flags_bench;
    reg         clk, srst, hsel, hwrite, rd_ph;
    reg  [7:0]  haddr;
    reg  [1:0]  htrans;
    reg  [31:0] hwdata;
    wire [31:0] hrdata;
    wire        hready, hresp, irq, v, rem, ovl;
    wire [3:0]  mb;
    wire [8:0]  tec, rec;
    reg  [31:0] exp_q[$];
    reg  [15:0] rx, rr;
    reg  [3:0]  ev4;
    integer     n_fail, samples_checked, i, m, r;

    crx_flags crx_flags_inst (.ref_clk_in(clk), .srst_in(srst),
        .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans),
        .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata),
        .hready_in(hready), .hrdata_out(hrdata), .hreadyout_out(hready),
        .hresp_out(hresp), .rx_done_valid_in(v), .rx_mailbox_in(mb),
        .rx_is_remote_in(rem), .overload_tx_in(ovl),
        .tx_err_count_in(tec), .rx_err_count_in(rec), .irq_out(irq));
    crx_can_node crx_can_node_inst (.ref_clk_in(clk),
        .rx_done_valid_out(v), .rx_mailbox_out(mb), .rx_is_remote_out(rem),
        .overload_tx_out(ovl), .tx_err_count_out(tec),
        .rx_err_count_out(rec));

    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    task chk(input [31:0] seen, input [31:0] want);
    begin
        samples_checked = samples_checked + 1;
        if (seen !== want)
        begin
            n_fail = n_fail + 1;
            $display("MISMATCH t=%0t seen=%h want=%h", $time, seen, want);
        end
    end
    endtask
    // read data is judged at the edge that ends its data phase
    always @(posedge clk)
        if (rd_ph && hready)
            chk(hrdata, exp_q.pop_front());
    // one single transfer; waits on hready, no fixed latency assumed
    task xfer(input [7:0] a, input w, input [31:0] d);
    begin
        @(posedge clk);
        hsel   <= 1'b1;
        haddr  <= a;
        hwrite <= w;
        htrans <= 2'h2;
        do @(posedge clk); while (!hready);
        htrans <= 2'h0;
        hwdata <= d;
        rd_ph  <= !w;
        do @(posedge clk); while (!hready);
        rd_ph  <= 1'b0;
    end
    endtask
    task rd(input [7:0] a, input [31:0] e);
    begin
        exp_q.push_back(e);
        xfer(a, 1'b0, 32'h0);
    end
    endtask
    function [15:0] mbit(input integer n);
        mbit = 16'h1 << (n < 8 ? n + 8 : n - 8);
    endfunction
    function [31:0] ev;
        ev = {16'h0, ev4, 1'b0, |rr, |rx, 9'h0};
    endfunction
    task tally_and_finish;
    begin
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    end
    endtask
    // hang guard, far beyond the few hundred cycles needed
    initial
    begin
        repeat (5000) @(posedge clk);
        n_fail = n_fail + 1;
        tally_and_finish;
    end
    initial
    begin
        {srst, hsel, hwrite, rd_ph} = 4'h8;
        {haddr, htrans, hwdata} = 42'h0;
        {rx, rr, ev4} = 36'h0;
        n_fail = 0;
        samples_checked = 0;
        r = $urandom(32'h4e1cd8a3);
        repeat (10) @(posedge clk);
        srst <= 1'b0;
        rd(8'h00, 32'h0);
        rd(8'h04, 32'h0);
        rd(8'h08, 32'h0);
        rd(8'h0C, 32'hFFFF);
        rd(8'h20, 32'h0);
        $display("test reset values done");
        wr_all: begin
            xfer(8'h18, 1'b1, 32'h3F);
            xfer(8'h0C, 1'b1, 32'h0);
        end
        rd(8'h18, 32'h3F);
        rd(8'h0C, 32'h0);
        m = $urandom % 16;
        for (i = 0; i < 16; i = i + 1)
        begin
            r = $urandom;
            crx_can_node_inst.frame((i * 7 + m) % 16, r[0] | (i == 0));
            @(posedge clk);
            rx = rx | mbit((i * 7 + m) % 16);
            if (r[0] | (i == 0))
                rr = rr | mbit((i * 7 + m) % 16);
            rd(8'h00, rx);
            rd(8'h04, rr);
        end
        rd(8'h08, ev());
        chk({31'h0, irq}, 32'h1);
        $display("test reception done");
        xfer(8'h00, 1'b1, 32'h0);
        rd(8'h00, rx);
        xfer(8'h00, 1'b1, mbit(m));
        rx = rx & ~mbit(m);
        rd(8'h00, rx);
        xfer(8'h04, 1'b1, 32'hFFFF);
        rr = 16'h0;
        rd(8'h08, ev());
        fork
            xfer(8'h00, 1'b1, mbit(m));
            begin
                repeat (2) @(posedge clk);
                crx_can_node_inst.frame(m, 1'b0);
            end
        join
        // the frame landed in the clearing cycle, so its bit survives
        rx = rx | mbit(m);
        rd(8'h00, rx);
        xfer(8'h00, 1'b1, 32'hFFFF);
        rx = 16'h0;
        rd(8'h08, ev());
        $display("test clearing done");
        crx_can_node_inst.counts(9'd0, 9'd95);
        rd(8'h08, ev());
        crx_can_node_inst.counts(9'd0, 9'd96);
        ev4 = 4'h1;
        rd(8'h08, ev());
        crx_can_node_inst.counts(9'd0, 9'd128);
        crx_can_node_inst.overload;
        ev4 = 4'hB;
        rd(8'h08, ev());
        xfer(8'h08, 1'b1, 32'hF000);
        ev4 = 4'h0;
        rd(8'h08, ev());
        crx_can_node_inst.counts(9'd256, 9'd128);
        crx_can_node_inst.overload;
        ev4 = 4'h4;
        rd(8'h08, ev());
        rd(8'h1C, {7'h0, 9'd128, 7'h0, 9'd256});
        rd(8'h10, 32'h3F);
        rd(8'h14, 32'h0);
        $display("test error counters done");
        xfer(8'h14, 1'b1, 32'h3F);
        xfer(8'h0C, 1'b1, 32'hFFFF);
        crx_can_node_inst.frame(m, 1'b1);
        @(posedge clk);
        rd(8'h08, 32'h4000);
        rd(8'h04, mbit(m));
        chk({31'h0, irq}, 32'h0);
        rd(8'h10, 32'h0);
        srst <= 1'b1;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        rd(8'h04, 32'h0);
        rd(8'h0C, 32'hFFFF);
        $display("test mask and reset done");
        tally_and_finish;
    end
endmodule // crx_flags_bench
